// ### hw/adc_host_cfg.svh
`ifndef ADC_HOST_CFG_SVH
`define ADC_HOST_CFG_SVH

`define DATA_BITS        5'd24
`define FORCE_HIGH_BITS  5'd25
`define CAL_BITS         5'd26
`define LAST_BIT_IDX     5'd23
`define SCLK_DIV_HALF    4'd4
`define CLK_PERIOD_NS    25
`define STBY_ENTRY_NS    100000
`define STBY_ENTRY_CYC   (((`STBY_ENTRY_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define SKEW_MAX_NS      2000
`define SKEW_MAX_CYC     (((`SKEW_MAX_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define CNT_W            24

`endif

// ### hw/adc_host_pkg.sv
package adc_host_pkg;
   typedef enum logic [1:0] {
      CMD_READ  = 2'h0,
      CMD_CAL   = 2'h1,
      CMD_STBY  = 2'h2,
      CMD_STCAL = 2'h3
   } cmd_e;

   typedef struct packed {
      logic       valid;
      cmd_e       cmd;
      logic       inputBufferOn;
      logic       tempSensorOn;
      logic       chanSel;
   } req_s;

   typedef struct packed {
      logic        valid;
      logic [23:0] data;
   } resp_s;
endpackage : adc_host_pkg

// ### hw/adc_serial_cal_standby_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_host_cfg.svh"
// Summary of operation
// - two or more extra shift clocks after a 24-bit readback request calibration
// - host may send more clocks after the 26th; keep them minimal
// - host holds shift clock high after ready low to request standby
// - host keeps shift clock high for the whole standby
// - host wakes device by driving shift clock low; first result valid
// - host may stop the system clock during standby
// - 25 bits before standby entry force calibration after wake-up
// - single shot: wake, wait ready low, read, return to standby; here a read ends in idle with the clock low, and standby needs a new request
// - host clears the input-buffer enable before and during standby
// - parallel devices share clocks, enter standby, start together
// - with parallel devices wait skew time or all ready lines low
// - host should calibrate once supplies and reference have settled
// - host finishes reading before the next result update

module adc_serial_cal_standby_ctrl (
   input  wire logic                 core_clk,
   input  wire logic                 nrst,
   input  wire logic                 linkClk,
   input  wire adc_host_pkg::req_s   req,
   output logic                      reqReady,
   output adc_host_pkg::resp_s       resp,
   output logic                      inStandby,
   input  wire logic                 readyDataIn,
   output logic                      sclkOut,
   output logic                      inputBufferOn,
   output logic                      tempSensorOn,
   output logic                      chanSel
);
   import adc_host_pkg::*;

   // link domain only watches the ready/data pin as a sampled probe; all
   // shifting is done from core_clk because this end makes the shift clock
   logic lkSync1_q;
   logic lkSync1_d;
   logic lkSync2_q;
   logic lkSync2_d;
   logic lkSeen_q;
   logic lkSeen_d;

   always_comb begin
      lkSync1_d = readyDataIn;
      lkSync2_d = lkSync1_q;
      lkSeen_d  = lkSync2_q;
   end

   always_ff @(posedge linkClk or negedge nrst) begin
      if (!nrst) begin
         lkSync1_q <= 1'b1;
         lkSync2_q <= 1'b1;
         lkSeen_q  <= 1'b1;
      end else begin
         lkSync1_q <= lkSync1_d;
         lkSync2_q <= lkSync2_d;
         lkSeen_q  <= lkSeen_d;
      end
   end

   // reset takes hold at once but is released on core_clk, so no core_clk flop sees half a release
   logic rstSync1_q;
   logic rstSync1_d;
   logic rstSync2_q;
   logic rstSync2_d;

   always_comb begin
      rstSync1_d = 1'b1;
      rstSync2_d = rstSync1_q;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rstSync1_q <= 1'b0;
         rstSync2_q <= 1'b0;
      end else begin
         rstSync1_q <= rstSync1_d;
         rstSync2_q <= rstSync2_d;
      end
   end
   wire logic rstN = rstSync2_q;

   // two stages before any logic reads the pin or the link-side copy
   logic rdySync1_q;
   logic rdySync1_d;
   logic rdySync2_q;
   logic rdySync2_d;
   logic lkBack1_q;
   logic lkBack1_d;
   logic lkBack2_q;
   logic lkBack2_d;

   always_comb begin
      rdySync1_d = readyDataIn;
      rdySync2_d = rdySync1_q;
      lkBack1_d  = lkSeen_q;
      lkBack2_d  = lkBack1_q;
   end

   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         rdySync1_q <= 1'b1;
         rdySync2_q <= 1'b1;
         lkBack1_q  <= 1'b1;
         lkBack2_q  <= 1'b1;
      end else begin
         rdySync1_q <= rdySync1_d;
         rdySync2_q <= rdySync2_d;
         lkBack1_q  <= lkBack1_d;
         lkBack2_q  <= lkBack2_d;
      end
   end
   // ready is taken low only when both samplers agree, masking a glitch
   wire logic rdyLow = !rdySync2_q && !lkBack2_q;
   wire logic rdyHigh = rdySync2_q && lkBack2_q;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SKEW,
      ST_HIGH,
      ST_LOW,
      ST_WAIT_CAL,
      ST_STBY,
      ST_WAKE
   } state_e;

   state_e               state_q,    state_d;
   cmd_e                 cmd_q,      cmd_d;
   logic [4:0]           pulses_q,   pulses_d;
   logic [3:0]           div_q,      div_d;
   logic [`CNT_W-1:0]    timer_q,    timer_d;
   logic [23:0]          shift_q,    shift_d;
   logic                 sclk_q,     sclk_d;
   logic                 reqRdy_q,   reqRdy_d;
   resp_s                resp_q,     resp_d;
   logic                 stby_q,     stby_d;
   logic                 buf_q,      buf_d;
   logic                 temp_q,     temp_d;
   logic                 chan_q,     chan_d;
   logic [4:0]           target;
   logic                 armed_q,    armed_d;
   logic                 take;

   // pulse count that ends each command
   always_comb begin
      case (cmd_q)
         CMD_READ:  target = `DATA_BITS;
         CMD_STCAL: target = `FORCE_HIGH_BITS;
         CMD_CAL:   target = `CAL_BITS;
         default:   target = 5'h00;
      endcase
   end

   always_comb begin
      state_d  = state_q;
      cmd_d    = cmd_q;
      pulses_d = pulses_q;
      div_d    = div_q;
      timer_d  = timer_q;
      shift_d  = shift_q;
      sclk_d   = sclk_q;
      reqRdy_d = 1'b0;
      resp_d   = '0;
      stby_d   = stby_q;
      armed_d  = armed_q;
      take     = 1'b0;

      case (state_q)
         ST_IDLE: begin
            reqRdy_d = 1'b1;
            if (req.valid && reqRdy_q) begin
               reqRdy_d = 1'b0;
               cmd_d    = req.cmd;
               take     = 1'b1;
               armed_d  = 1'b0;
               pulses_d = 5'h00;
               // a request while in standby is also the wake-up
               timer_d  = '0;
               state_d  = stby_q ? ST_WAKE : ST_WAIT_CAL;
               if (stby_q) begin
                  sclk_d = 1'b0;
                  stby_d = 1'b0;
               end
            end
         end

         ST_WAKE: begin
            state_d = ST_WAIT_CAL;
         end

         ST_WAIT_CAL: begin
            // any wait, calibration included, ends on ready low
            // the pin may still hold the last data bit, so a high must be seen first
            if (!armed_q) begin
               armed_d = rdyHigh;
            end else if (rdyLow) begin
               timer_d = '0;
               state_d = ST_SKEW;
            end
         end

         ST_SKEW: begin
            // a zero-pulse standby command raises the clock once the skew wait ends
            timer_d = timer_q + 1'b1;
            if (timer_q == `CNT_W'(`SKEW_MAX_CYC)) begin
               timer_d = '0;
               div_d   = 4'h0;
               state_d = (target == pulses_q) ? ST_STBY : ST_LOW;
               if (target == pulses_q) begin
                  sclk_d = 1'b1;
               end
            end
         end

         ST_LOW: begin
            div_d = div_q + 1'b1;
            if (div_q == `SCLK_DIV_HALF) begin
               div_d    = 4'h0;
               sclk_d   = 1'b1;
               pulses_d = pulses_q + 1'b1;
               state_d  = ST_HIGH;
            end
         end

         ST_HIGH: begin
            div_d = div_q + 1'b1;
            if (pulses_q == target && (cmd_q == CMD_STBY || cmd_q == CMD_STCAL)) begin
               div_d   = 4'h0;
               timer_d = '0;
               state_d = ST_STBY;
            end else if (div_q == `SCLK_DIV_HALF) begin
               div_d  = 4'h0;
               sclk_d = 1'b0;              // falling edge of 26th starts calibration
               // the device moves its pin on the rise; sampling before the fall lets it settle
               if (pulses_q <= `DATA_BITS) begin
                  shift_d = {shift_q[`LAST_BIT_IDX-1:0], rdySync2_q};
               end
               if (pulses_q == target) begin
                  resp_d.valid = 1'b1;
                  resp_d.data  = shift_d;
                  state_d      = (cmd_q == CMD_CAL) ? ST_WAIT_CAL : ST_IDLE;
                  if (cmd_q == CMD_CAL) begin
                     pulses_d = 5'h00;
                     armed_d  = 1'b0;
                     cmd_d    = CMD_READ;
                  end
               end else begin
                  state_d = ST_LOW;        // pulse 25 passes on its way to 26
               end
            end
         end

         ST_STBY: begin
            // clock stays high; wait out the entry delay
            timer_d = timer_q + 1'b1;
            if (timer_q == `CNT_W'(`STBY_ENTRY_CYC)) begin
               resp_d.valid = 1'b1;
               resp_d.data  = shift_q;
               stby_d       = 1'b1;
               cmd_d        = CMD_READ;
               state_d      = ST_IDLE;
            end
         end

         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         state_q  <= ST_WAIT_CAL;
         cmd_q    <= CMD_READ;
         pulses_q <= 5'h00;
         div_q    <= 4'h0;
         timer_q  <= '0;
         shift_q  <= 24'h000000;
         sclk_q   <= 1'b0;
         reqRdy_q <= 1'b0;
         resp_q   <= '0;
         stby_q   <= 1'b0;
         armed_q  <= 1'b0;
      end else begin
         state_q  <= state_d;
         cmd_q    <= cmd_d;
         pulses_q <= pulses_d;
         div_q    <= div_d;
         timer_q  <= timer_d;
         shift_q  <= shift_d;
         sclk_q   <= sclk_d;
         reqRdy_q <= reqRdy_d;
         resp_q   <= resp_d;
         stby_q   <= stby_d;
         armed_q  <= armed_d;
      end
   end

   // pin levels move only on acceptance, so the device sees one clean toggle per request
   always_comb begin
      buf_d  = buf_q;
      temp_d = temp_q;
      chan_d = chan_q;
      if (take) begin
         temp_d = req.tempSensorOn;
         chan_d = req.chanSel;
         buf_d  = (req.cmd == CMD_STBY || req.cmd == CMD_STCAL) ? 1'b0 : req.inputBufferOn;
      end
   end

   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         buf_q  <= 1'b0;
         temp_q <= 1'b0;
         chan_q <= 1'b0;
      end else begin
         buf_q  <= buf_d;
         temp_q <= temp_d;
         chan_q <= chan_d;
      end
   end

   assign reqReady      = reqRdy_q;
   assign resp          = resp_q;
   assign inStandby     = stby_q;
   assign sclkOut       = sclk_q;
   assign inputBufferOn = buf_q;
   assign tempSensorOn  = temp_q;
   assign chanSel       = chan_q;
endmodule : adc_serial_cal_standby_ctrl
`default_nettype wire

// ### tb/adc_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_props (
   input  wire logic                core_clk,
   input  wire logic                nrst,
   input  wire logic                reqReady,
   input  wire adc_host_pkg::resp_s resp,
   input  wire logic                inStandby,
   input  wire logic                sclkOut,
   input  wire logic                inputBufferOn,
   input  wire logic                chanSel
);
   import adc_host_pkg::*;
   // saturating count of cycles the shift clock has been high
   logic [12:0] hiCnt_q;
   logic [12:0] hiCnt_d;
   always_comb hiCnt_d = !sclkOut ? 13'h0 : (&hiCnt_q ? hiCnt_q : hiCnt_q + 13'h1);
   always_ff @(posedge core_clk or negedge nrst) if (!nrst) hiCnt_q <= 13'h0; else hiCnt_q <= hiCnt_d;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   resp_pulse_a: assert property (resp.valid |=> !resp.valid)
      else $error("result pulse longer than one cycle");
   sclk_high_a: assert property ($rose(sclkOut) |-> sclkOut[*5])
      else $error("shift clock high phase short");
   sclk_low_a: assert property ($fell(sclkOut) |-> !sclkOut[*5])
      else $error("shift clock low phase short");
   stby_hold_a: assert property (inStandby |-> sclkOut)
      else $error("shift clock low during standby");
   stby_buf_a: assert property (inStandby |-> !inputBufferOn)
      else $error("buffer enabled during standby");
   idle_quiet_a: assert property (reqReady && !sclkOut |=> !sclkOut)
      else $error("shift clock started while idle");
   stby_entry_a: assert property ($rose(inStandby) |-> hiCnt_q >= 13'd3990)
      else $error("standby flagged before entry delay");
   pin_hold_a: assert property (!reqReady && !$past(reqReady) |-> $stable(chanSel))
      else $error("channel select moved mid operation");
endmodule : adc_ctrl_props
bind adc_serial_cal_standby_ctrl adc_ctrl_props u_props (.core_clk(core_clk), .nrst(nrst), .reqReady(reqReady),
   .resp(resp), .inStandby(inStandby), .sclkOut(sclkOut), .inputBufferOn(inputBufferOn), .chanSel(chanSel));
`default_nettype wire

// ### tb/adc_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_dev_model #(
   parameter int CONV = 60,
   parameter int CAL  = 150,
   parameter int STBY = 3000
) (
   input  wire logic        clk,
   input  wire logic        sclk,
   output logic             rdy,
   output logic [23:0]      word
);
   int cnt;
   int n;
   int waitN;
   initial begin
      rdy = 1'b1;
      word = 24'hC35A97;
      waitN = CAL;
      forever begin
         repeat (waitN) @(posedge clk);
         // the pin keeps the last bit for up to 120 cycles after a plain read, low included
         word = {word[22:0], ~word[23]} ^ 24'h00F00F;
         rdy = 1'b0;
         cnt = 0;
         waitN = 0;
         while (waitN == 0) begin
            n = 0;
            while (!sclk && n < 120) begin @(posedge clk); n++; end
            if (!sclk) begin
               rdy = 1'b1;
               waitN = CONV;
            end else begin
               cnt++;
               rdy = (cnt <= 24) ? word[24 - cnt] : 1'b1;
               n = 0;
               while (sclk && n < STBY) begin @(posedge clk); n++; end
               if (sclk) begin
                  rdy = 1'b1;
                  wait (!sclk);
                  waitN = (cnt >= 25) ? CAL + CONV : CONV;
               end else if (cnt == 26) waitN = CAL;
            end
         end
      end
   end
endmodule : adc_dev_model
`default_nettype wire

// ### tb/tb_adc_serial_cal_standby_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adc_serial_cal_standby_ctrl;
   import adc_host_pkg::*;
   logic core_clk, nrst, linkClk, rdy, reqReady, inStandby, sclkOut, bufOn, tempOn, chanSel;
   req_s        req;
   resp_s       resp;
   logic [23:0] word;
   logic [23:0] got;
   int          n_mismatch, num_checks, cycles, rises, n;
   initial begin core_clk = 0; forever #12.5 core_clk = ~core_clk; end
   initial begin linkClk = 0; #17; forever #62.5 linkClk = ~linkClk; end
   adc_serial_cal_standby_ctrl uut (.core_clk(core_clk), .nrst(nrst), .linkClk(linkClk), .req(req),
      .reqReady(reqReady), .resp(resp), .inStandby(inStandby), .readyDataIn(rdy), .sclkOut(sclkOut),
      .inputBufferOn(bufOn), .tempSensorOn(tempOn), .chanSel(chanSel));
   adc_dev_model dev (.clk(core_clk), .sclk(sclkOut), .rdy(rdy), .word(word));
   always @(posedge sclkOut) rises++;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles > 30000) begin n_mismatch++; print_verdict(); end
   end
   task print_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict
   task check(input logic [23:0] g, input logic [23:0] e);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : check
   // waits for the block to go idle, keeping the last result seen meanwhile
   task wait_idle;
      for (n = 0; n < 20000 && reqReady !== 1'b1; n++) begin
         @(posedge core_clk);
         if (resp.valid === 1'b1) got = resp.data;
      end
      check(24'(reqReady), 24'h1);
   endtask : wait_idle
   task op(input cmd_e c, input logic b);
      @(posedge core_clk);
      req <= '{1'b1, c, b, b, b};
      rises = 0;
      got = 24'h0;
      @(posedge core_clk);
      req.valid <= 1'b0;
      @(posedge core_clk);
      wait_idle();
   endtask : op
   task t_read;
      op(CMD_READ, 1'b1);
      check(got, word);
      check(24'(rises), 24'd24);
      check(24'(chanSel), 24'h1);
      check(24'(tempOn), 24'h1);
      $display("test read done");
   endtask : t_read
   task t_cal;
      op(CMD_CAL, 1'b0);
      check(got, word);
      check(24'(rises), 24'd50);
      op(CMD_READ, 1'b1);
      check(got, word);
      $display("test calibrate done");
   endtask : t_cal
   task t_stby(input cmd_e c);
      op(c, 1'b1);
      check(24'(inStandby), 24'h1);
      check(24'(bufOn), 24'h0);
      op(CMD_READ, 1'b1);
      check(got, word);
      check(24'(inStandby), 24'h0);
      $display("test standby done");
   endtask : t_stby
   initial begin
      nrst = 1'b0;
      req = '0;
      repeat (8) @(posedge core_clk);
      nrst <= 1'b1;
      wait_idle();
      check(got, word);
      t_read();
      t_read();
      t_cal();
      t_stby(CMD_STBY);
      t_stby(CMD_STCAL);
      print_verdict();
   end
endmodule : tb_adc_serial_cal_standby_ctrl
`default_nettype wire
